//--- rtl/ckc_pkg.sv
package ckc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_GATE = 8'h00;  // peripheral_clock_gate_first
    localparam logic [7:0] ADDR_SEL = 8'h04;   // source select request
    localparam logic [7:0] ADDR_STAT = 8'h08;  // status, read only
    localparam logic [7:0] ADDR_OPT = 8'h0c;   // watchdog option pair
    localparam logic [7:0] ADDR_MON_EN = 8'h10; // monitor enable
    localparam logic [7:0] ADDR_FAIL = 8'h14;  // failure flag, write 1 clear
    // reset values
    localparam logic [7:0] GATE_RST = 8'hff;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [7:0] OPT_RST = 8'h00;
    localparam logic [7:0] NOPT_RST = 8'hff;
    // field positions
    localparam int OPT_LS_ALLOW_BIT = 3;
    localparam int OPT_LO = 0;
    localparam int NOPT_LO = 8;
    localparam int STAT_SRC_LO = 0;
    localparam int STAT_FAIL_BIT = 2;
    localparam int STAT_OPT_ERR_BIT = 3;
    // source select codes
    localparam logic [1:0] SRC_HSRC = 2'h0;   // high_speed_rc_osc
    localparam logic [1:0] SRC_XTAL = 2'h1;   // high_speed_crystal_osc
    localparam logic [1:0] SRC_LSRC = 2'h2;   // low_speed_rc_osc
    localparam logic [1:0] SRC_HSRC8 = 2'h3;  // fallback, rc divided by 8
    // timing
    localparam int CLK_KHZ = 40000;
    localparam int LS_KHZ = 128;
    localparam int LS_HALF = CLK_KHZ / (2 * LS_KHZ);
    localparam int FAIL_MIN_KHZ = 500;
    // window without a crystal edge that counts as failure
    localparam int FAIL_CYC = (CLK_KHZ + FAIL_MIN_KHZ - 1) / FAIL_MIN_KHZ;
    localparam int FALLBACK_DIV = 8;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

//--- rtl/ckc_clock_control.sv
`timescale 1ns/1ps
module ckc_clock_control
    import ckc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic osc_input_pin,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic lowspeed_tick,
    output logic [1:0] sysclk_source,
    output logic [7:0] periph_clk_en,
    output logic clock_fail_irq
);
    logic xin_s1, xin_s2, xin_s3;
    logic [7:0] gate, next_gate;
    logic [1:0] sel_req, next_sel_req;
    logic [15:0] opt, next_opt;
    logic mon_en, next_mon_en;
    logic fail, next_fail;
    logic [1:0] src, next_src;
    logic [15:0] ls_cnt, next_ls_cnt;
    logic ls_tick, next_ls_tick;
    logic [15:0] mon_cnt, next_mon_cnt;
    logic aw_hold, next_aw_hold, w_hold, next_w_hold;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bv, next_bv, rv, next_rv;
    logic [1:0] br, next_br, rr, next_rr;
    logic [31:0] rd, next_rd;
    logic do_wr, opt_ok, ls_allow, xin_edge, fail_evt;
    logic wr_mapped, fail_clr;

    // crystal pin synchroniser, edge seen only past the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xin_s1 <= 1'b0;
            xin_s2 <= 1'b0;
            xin_s3 <= 1'b0;
        end else begin
            xin_s1 <= osc_input_pin;
            xin_s2 <= xin_s1;
            xin_s3 <= xin_s2;
        end
    end

    assign xin_edge = xin_s2 & ~xin_s3;
    // pair valid only when second byte is exact complement
    assign opt_ok = (opt[NOPT_LO +: 8] == ~opt[OPT_LO +: 8]);
    assign ls_allow = opt_ok & opt[OPT_LO + OPT_LS_ALLOW_BIT];
    assign fail_evt = mon_en & (src == SRC_XTAL) & (mon_cnt >= 16'(FAIL_CYC));
    assign do_wr = aw_hold & w_hold & ~bv;

    // bus handshakes
    assign awready = ~aw_hold;
    assign wready = ~w_hold;
    assign arready = ~rv;
    assign bvalid = bv;
    assign bresp = br;
    assign rvalid = rv;
    assign rresp = rr;
    assign rdata = rd;

    // outputs
    assign lowspeed_tick = ls_tick;
    assign sysclk_source = src;
    assign periph_clk_en = gate;
    assign clock_fail_irq = fail;

    // write decode: which byte addresses answer a write with okay
    always_comb begin
        unique case (aw_addr)
            ADDR_GATE, ADDR_SEL, ADDR_STAT, ADDR_OPT: begin
                wr_mapped = 1'b1;
            end
            ADDR_MON_EN, ADDR_FAIL: begin
                wr_mapped = 1'b1;
            end
            default: begin
                wr_mapped = 1'b0;
            end
        endcase
    end

    // write channel: hold address and data until both are in
    always_comb begin
        next_aw_hold = aw_hold;
        next_w_hold = w_hold;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bv = bv;
        next_br = br;
        if (awvalid && awready) begin
            next_aw_hold = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_hold = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (bv && bready) begin
            next_bv = 1'b0;
        end
        // both halves in: commit now, answer on the next edge
        if (do_wr) begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bv = 1'b1;
            next_br = wr_mapped ? AXI_OKAY : AXI_SLVERR;
        end
    end

    // write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bv <= 1'b0;
            br <= AXI_OKAY;
        end else begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bv <= next_bv;
            br <= next_br;
        end
    end

    // software registers, updated when a write commits
    always_comb begin
        next_gate = gate;
        next_sel_req = sel_req;
        next_opt = opt;
        next_mon_en = mon_en;
        fail_clr = 1'b0;
        if (do_wr) begin
            unique case (aw_addr)
                ADDR_GATE: begin
                    if (w_strb[0]) next_gate = w_data[7:0];
                end
                ADDR_SEL: begin
                    if (w_strb[0]) next_sel_req = w_data[1:0];
                end
                ADDR_OPT: begin
                    if (w_strb[0]) next_opt[7:0] = w_data[7:0];
                    if (w_strb[1]) next_opt[15:8] = w_data[15:8];
                end
                ADDR_MON_EN: begin
                    if (w_strb[0]) next_mon_en = w_data[0];
                end
                ADDR_FAIL: begin
                    fail_clr = w_strb[0] & w_data[0];
                end
                default: ;
            endcase
        end
    end

    // software register state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate <= GATE_RST;
            sel_req <= SEL_RST;
            opt <= {NOPT_RST, OPT_RST};
            mon_en <= 1'b0;
        end else begin
            gate <= next_gate;
            sel_req <= next_sel_req;
            opt <= next_opt;
            mon_en <= next_mon_en;
        end
    end

    // clock state: crystal monitor, failure flag and source
    always_comb begin
        next_fail = fail;
        next_src = src;
        next_mon_cnt = mon_cnt;
        // cycles since the last synced crystal edge
        if (xin_edge || src != SRC_XTAL) begin
            next_mon_cnt = 16'h0000;
        end else if (mon_cnt < 16'(FAIL_CYC)) begin
            next_mon_cnt = mon_cnt + 16'h0001;
        end
        // write one clears the flag
        if (fail_clr) begin
            next_fail = 1'b0;
        end
        // fallback overrides selection; a failure beats a clear
        if (fail_evt) begin
            next_fail = 1'b1;
            next_src = SRC_HSRC8;
        end else if (!fail) begin
            unique case (sel_req)
                SRC_XTAL: next_src = SRC_XTAL;
                SRC_LSRC: next_src = ls_allow ? SRC_LSRC : SRC_HSRC;
                default: next_src = SRC_HSRC;
            endcase
        end else begin
            next_src = SRC_HSRC8;
        end
    end

    // clock state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fail <= 1'b0;
            src <= SRC_HSRC;
            mon_cnt <= 16'h0000;
        end else begin
            fail <= next_fail;
            src <= next_src;
            mon_cnt <= next_mon_cnt;
        end
    end

    // free-running low-speed divider, one tick per half period
    always_comb begin
        next_ls_cnt = ls_cnt + 16'h0001;
        next_ls_tick = 1'b0;
        if (ls_cnt >= 16'(LS_HALF - 1)) begin
            next_ls_cnt = 16'h0000;
            next_ls_tick = 1'b1;
        end
    end

    // low-speed divider registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ls_cnt <= 16'h0000;
            ls_tick <= 1'b0;
        end else begin
            ls_cnt <= next_ls_cnt;
            ls_tick <= next_ls_tick;
        end
    end

    // read channel: answer one cycle after the address is taken
    always_comb begin
        next_rv = rv;
        next_rr = rr;
        next_rd = rd;
        if (rv && rready) begin
            next_rv = 1'b0;
        end
        if (arvalid && arready) begin
            next_rv = 1'b1;
            next_rr = AXI_OKAY;
            next_rd = 32'h0000_0000;
            unique case (araddr)
                ADDR_GATE: next_rd[7:0] = gate;
                ADDR_SEL: next_rd[1:0] = sel_req;
                ADDR_STAT: begin
                    next_rd[STAT_SRC_LO +: 2] = src;
                    next_rd[STAT_FAIL_BIT] = fail;
                    next_rd[STAT_OPT_ERR_BIT] = ~opt_ok;
                end
                ADDR_OPT: next_rd[15:0] = opt;
                ADDR_MON_EN: next_rd[0] = mon_en;
                ADDR_FAIL: next_rd[0] = fail;
                default: next_rr = AXI_SLVERR;
            endcase
        end
    end

    // read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rv <= 1'b0;
            rr <= AXI_OKAY;
            rd <= 32'h0000_0000;
        end else begin
            rv <= next_rv;
            rr <= next_rr;
            rd <= next_rd;
        end
    end
endmodule

//--- verif/ckc_xtal_model.sv
`timescale 1ns/1ps
module ckc_xtal_model (
    input wire logic run,
    output logic osc_input_pin
);
    // 4 MHz crystal while running; a dead crystal freezes
    initial begin
        osc_input_pin = 1'b0;
        forever begin
            #125;
            if (run) begin
                osc_input_pin = ~osc_input_pin;
            end
        end
    end
endmodule

//--- verif/ckc_assertions.sv
`timescale 1ns/1ps
module ckc_assertions
    import ckc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic lowspeed_tick,
    input wire logic [1:0] sysclk_source,
    input wire logic [7:0] periph_clk_en,
    input wire logic clock_fail_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // bus answers stand until taken
    bvalid_hold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("bvalid dropped early");
    rvalid_hold_a: assert property (rvalid && !rready |=> rvalid)
        else $error("rvalid dropped early");
    ar_block_a: assert property (rvalid |-> !arready)
        else $error("arready while rvalid");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("late read answer");
    // tick is a short pulse with long gaps
    tick_gap_a: assert property (lowspeed_tick |=> (!lowspeed_tick)[*8])
        else $error("tick too dense");
    fail_src_a: assert property (clock_fail_irq |->
        sysclk_source == SRC_HSRC8)
        else $error("no fallback on failure");
    fail_cause_a: assert property ($rose(clock_fail_irq) |->
        $past(sysclk_source) == SRC_XTAL)
        else $error("failure without crystal");
    gate_write_a: assert property ($changed(periph_clk_en) |->
        $rose(bvalid))
        else $error("gate changed without write");
endmodule

//--- verif/ckc_clock_control_tb.sv
`timescale 1ns/1ps
module ckc_clock_control_tb import ckc_pkg::*;;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run;
    logic awready, wready, bvalid, arready, rvalid, osc, tick, irq;
    logic [7:0] awaddr, araddr, gate;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, src, r;
    int fails, n_checks, n;
    ckc_clock_control dut(.aclk(aclk), .aresetn(aresetn),
        .osc_input_pin(osc), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .lowspeed_tick(tick), .sysclk_source(src), .periph_clk_en(gate),
        .clock_fail_irq(irq));
    ckc_xtal_model xtal(.run(run), .osc_input_pin(osc));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic settle(input int c);
        repeat (c) @(posedge aclk);
        #1;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [1:0] resp,
                      output logic [31:0] v);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        resp = rresp;
        v = rdata;
        rready <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        print_verdict;
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
        {awaddr, araddr, wdata} = '0;
        {wstrb, run, fails, n_checks} = {4'hf, 1'b1, 64'h0};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        settle(1);
        chk(32'(gate), 32'(GATE_RST));
        rd(ADDR_OPT, r, d);
        chk(32'(r), 32'(AXI_OKAY));
        chk(d, {16'h0, NOPT_RST, OPT_RST});
        // walking one over the gate bits
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_GATE, 32'h1 << i, r);
            settle(1);
            chk(32'(gate), 32'h1 << i);
        end
        chk(32'(r), 32'(AXI_OKAY));
        rd(ADDR_GATE, r, d);
        chk(d, 32'h0000_0080);
        wr(ADDR_SEL, 32'(SRC_LSRC), r);
        settle(3);
        chk(32'(src), 32'(SRC_HSRC));
        wr(ADDR_OPT, 32'h0000f708, r);
        wr(ADDR_SEL, 32'(SRC_XTAL), r);
        wr(ADDR_SEL, 32'(SRC_LSRC), r);
        settle(3);
        chk(32'(src), 32'(SRC_LSRC));
        wr(ADDR_SEL, 32'(SRC_XTAL), r);
        settle(3);
        chk(32'(src), 32'(SRC_XTAL));
        // broken option pair refuses the low-speed source
        wr(ADDR_OPT, 32'h0000ff08, r);
        rd(ADDR_STAT, r, d);
        chk(32'(d[STAT_OPT_ERR_BIT]), 32'h1);
        wr(ADDR_SEL, 32'(SRC_LSRC), r);
        settle(3);
        chk(32'(src), 32'(SRC_HSRC));
        // crystal dies under the monitor
        wr(ADDR_MON_EN, 32'h1, r);
        wr(ADDR_SEL, 32'(SRC_XTAL), r);
        settle(100);
        chk(32'(irq), 32'h0);
        run = 1'b0;
        settle(FAIL_CYC + 10);
        chk(32'(irq), 32'h1);
        chk(32'(src), 32'(SRC_HSRC8));
        rd(ADDR_STAT, r, d);
        chk(32'(d[STAT_FAIL_BIT]), 32'h1);
        chk(32'(d[STAT_SRC_LO +: 2]), 32'(SRC_HSRC8));
        run = 1'b1;
        settle(20);
        wr(ADDR_FAIL, 32'h1, r);
        settle(3);
        chk({31'h0, irq}, 32'h0);
        chk(32'(src), 32'(SRC_XTAL));
        rd(8'h20, r, d);
        chk(32'(r), 32'(AXI_SLVERR));
        chk(d, 32'h0);
        wr(8'h20, 32'h5, r);
        chk(32'(r), 32'(AXI_SLVERR));
        // spacing of the low-speed tick
        do settle(1); while (tick !== 1'b1);
        n = 0;
        do begin
            settle(1);
            n++;
        end while (tick !== 1'b1);
        chk(32'(n), 32'(LS_HALF));
        print_verdict;
    end
endmodule
bind ckc_clock_control ckc_assertions chk_i(.aclk(aclk),
    .aresetn(aresetn), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rready(rready), .lowspeed_tick(lowspeed_tick),
    .sysclk_source(sysclk_source), .periph_clk_en(periph_clk_en),
    .clock_fail_irq(clock_fail_irq));
